// file: rtl/fsr_status_bank.sv
// status and configuration register bank of a serial flash, with its serial front end
// assumes program/erase engine and protection map on SYS_CLK; host drives SCK, CS_N, SI
`timescale 1ns/1ps
module fsr_status_bank
    import fsr_pkg::*;
#(
    parameter int WRITE_CYC = STATUS_WRITE_CYC
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic FACTORY_RST,
    input wire logic SCK,
    input wire logic CS_N,
    input wire logic SI,
    output logic SO,
    output logic SO_OE,
    input wire logic WP_N,
    input wire logic HIGH_SPEED_MODE,
    input wire logic PE_BUSY,
    input wire logic PROT_HIT,
    output logic PE_START,
    output fsr_kind_t PE_KIND,
    output logic [23:0] PE_ADDR,
    output logic PE_SUSPEND,
    output logic PE_RESUME,
    output logic SOFT_RESET,
    output logic QUAD_LANES_ON,
    output logic [4:0] AREA_PROTECT,
    output logic PROTECT_INVERT,
    output logic [2:0] SEC_REG_READ_ONLY,
    output logic [1:0] DRIVE_STRENGTH,
    output logic [23:0] STATUS
);
    fsr_nv_t nv;
    fsr_nv_t next_nv;
    fsr_frame_t frame;
    fsr_state_t state;
    logic [23:0] snap;
    logic [23:0] status_now;
    logic [15:0] write_cnt;
    logic [2:0] sec_now;
    logic [7:0] op;
    logic cs_meta, cs_sync, cs_prev;
    logic seq_meta, seq_sync, seq_used, link_seq;
    logic wp_meta, wp_sync;
    logic write_permit_latch, busy_flag, erase_paused, program_paused, reset_armed;
    logic ev, wp_low, lock_ok, chip_ok, whole_bytes;
    logic is_wr_op, is_swrite, is_prog, is_wipe, is_all;
    logic nv_wr, pe_go, soft_go, suspend_ev, resume_ev;

    fsr_link u_link (
        .sck(SCK),
        .cs_n(CS_N),
        .rst(RST),
        .si(SI),
        .status_word(snap),
        .frame(frame),
        .seq(link_seq),
        .so(SO),
        .so_oe(SO_OE)
    );

    fsr_nv_store u_nv (
        .clk(SYS_CLK),
        .factory_rst(FACTORY_RST),
        .power_rst(RST),
        .wr_en(nv_wr),
        .wr_data(next_nv),
        .nv(nv)
    );

    // pins and link toggle through two flops each
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
            seq_meta <= 1'b0;
            seq_sync <= 1'b0;
            wp_meta <= 1'b1;
            wp_sync <= 1'b1;
        end else begin
            cs_meta <= CS_N;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
            seq_meta <= link_seq;
            seq_sync <= seq_meta;
            wp_meta <= WP_N;
            wp_sync <= wp_meta;
        end
    end

    // the toggle tells a real frame from a select pulse with no clocks
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            seq_used <= 1'b0;
        end else if (ev) begin
            seq_used <= seq_sync;
        end
    end

    // link record is still by the time the synced select rises
    assign ev = cs_sync && !cs_prev && (seq_sync != seq_used);
    assign op = frame.opcode;
    assign whole_bytes = (frame.bits[2:0] == 3'h0);
    assign wp_low = !nv.four_lane && !wp_sync;
    assign chip_ok = (nv.area[2:0] == 3'h0 && !nv.invert)
        || (nv.area[2:0] == 3'h7 && nv.invert);

    always_comb begin
        case (nv.lock_mode)
            LOCK_SOFT: lock_ok = 1'b1;
            LOCK_PIN: lock_ok = !wp_low;
            default: lock_ok = 1'b0;
        endcase
    end

    assign is_wr_op = op == OP_WRITE_LOW || op == OP_WRITE_MID || op == OP_WRITE_HIGH;
    assign is_swrite = is_wr_op && frame.bits == BITS_WRITE;
    assign is_prog = (op == OP_PROGRAM || op == OP_PROGRAM_QUAD || op == OP_PROGRAM_FAST)
        && whole_bytes && frame.bits >= BITS_PROGRAM_MIN;
    assign is_wipe = (op == OP_WIPE_SMALL || op == OP_WIPE_BLOCK32 || op == OP_WIPE_BLOCK64)
        && frame.bits == BITS_ADDR;
    assign is_all = (op == OP_WIPE_ALL_A || op == OP_WIPE_ALL_B) && frame.bits == BITS_CMD;
    assign nv_wr = ev && is_swrite && write_permit_latch && lock_ok && !busy_flag;
    assign pe_go = ev && write_permit_latch && !busy_flag && (is_prog || is_wipe || is_all);
    assign soft_go = ev && op == OP_RESET_GO && frame.bits == BITS_CMD && reset_armed;
    assign suspend_ev = ev && op == OP_SUSPEND && frame.bits == BITS_CMD && PE_BUSY;
    assign resume_ev = ev && op == OP_RESUME && frame.bits == BITS_CMD;

    function automatic fsr_nv_t merge(input fsr_nv_t cur, input logic [7:0] code,
        input logic [7:0] d);
        fsr_nv_t res;
        res = cur;
        if (code == OP_WRITE_LOW) begin
            res.lock_mode[0] = d[POS_LOCK_LO];
            res.area = d[POS_AREA +: 5];
        end else if (code == OP_WRITE_MID) begin
            res.lock_mode[1] = d[POS_LOCK_HI];
            res.four_lane = d[POS_FOUR_LANE];
            res.sec_lock = d[POS_SEC +: 3];
            res.invert = d[POS_INVERT];
        end else if (code == OP_WRITE_HIGH) begin
            res.drive = d[POS_DRIVE +: 2];
        end
        return res;
    endfunction : merge

    // read-only and reserved positions of the data byte are dropped here
    assign next_nv = merge(nv, op, frame.addr[7:0]);

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            write_permit_latch <= 1'b0;
        end else if (soft_go) begin
            write_permit_latch <= 1'b0;
        end else if (ev && op == OP_WRITE_PERMIT && frame.bits == BITS_CMD) begin
            write_permit_latch <= 1'b1;
        end else if (ev && op == OP_WRITE_FORBID && frame.bits == BITS_CMD) begin
            write_permit_latch <= 1'b0;
        end else if (ev && (is_swrite || ((is_prog || is_wipe || is_all) && !busy_flag))) begin
            write_permit_latch <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            reset_armed <= 1'b0;
        end else if (ev) begin
            reset_armed <= op == OP_RESET_ARM && frame.bits == BITS_CMD;
        end
    end

    // engine must raise PE_BUSY the cycle after PE_START, no gap is covered
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state <= ST_IDLE;
            write_cnt <= 16'h0000;
            PE_START <= 1'b0;
            PE_KIND <= KIND_PROGRAM;
            PE_ADDR <= 24'h000000;
        end else begin
            PE_START <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (nv_wr) begin
                        state <= ST_SWRITE;
                        write_cnt <= 16'(WRITE_CYC - 1);
                    end else if (pe_go) begin
                        PE_ADDR <= frame.addr;
                        if (is_all) begin
                            PE_KIND <= KIND_ERASE_ALL;
                            PE_START <= chip_ok;
                        end else begin
                            PE_KIND <= is_prog ? KIND_PROGRAM : KIND_ERASE_AREA;
                            state <= ST_CHECK;
                        end
                    end
                end
                ST_CHECK: begin
                    PE_START <= !PROT_HIT;
                    state <= ST_IDLE;
                end
                ST_SWRITE: begin
                    if (write_cnt == 16'h0000) begin
                        state <= ST_IDLE;
                    end else begin
                        write_cnt <= write_cnt - 16'h0001;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            erase_paused <= 1'b0;
            program_paused <= 1'b0;
        end else if (soft_go || resume_ev) begin
            erase_paused <= 1'b0;
            program_paused <= 1'b0;
        end else if (suspend_ev) begin
            if (PE_KIND == KIND_PROGRAM) begin
                program_paused <= 1'b1;
            end else begin
                erase_paused <= 1'b1;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            PE_SUSPEND <= 1'b0;
            PE_RESUME <= 1'b0;
            SOFT_RESET <= 1'b0;
        end else begin
            PE_SUSPEND <= suspend_ev;
            PE_RESUME <= resume_ev;
            SOFT_RESET <= soft_go;
        end
    end

    assign busy_flag = PE_BUSY || state != ST_IDLE;
    assign status_now = {1'b0, nv.drive, HIGH_SPEED_MODE, 4'h0, erase_paused, nv.invert,
        nv.sec_lock, program_paused, nv.four_lane, nv.lock_mode, nv.area,
        write_permit_latch, busy_flag};

    // snapshot freezes within three cycles of the select, long before the first read bit;
    // a long read therefore shows the status as it stood at frame start
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            snap <= 24'h000000;
            STATUS <= 24'h000000;
        end else begin
            STATUS <= status_now;
            if (cs_sync) begin
                snap <= status_now;
            end
        end
    end

    assign QUAD_LANES_ON = nv.four_lane;
    assign AREA_PROTECT = nv.area;
    assign PROTECT_INVERT = nv.invert;
    assign SEC_REG_READ_ONLY = nv.sec_lock;
    assign DRIVE_STRENGTH = nv.drive;
    assign sec_now = nv.sec_lock;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);

    property p_write_busy;
        nv_wr |=> busy_flag && state == ST_SWRITE;
    endproperty
    a_write_busy: assert property (p_write_busy) else $error("busy not set by status write");

    property p_no_latch;
        ev && !write_permit_latch |-> !nv_wr && !pe_go;
    endproperty
    a_no_latch: assert property (p_no_latch) else $error("write taken without latch");

    property p_pin_lock;
        ev && nv.lock_mode == LOCK_PIN && wp_low |-> !nv_wr;
    endproperty
    a_pin_lock: assert property (p_pin_lock) else $error("write taken under pin lock");

    property p_power_lock;
        nv.lock_mode == LOCK_POWER |-> !nv_wr;
    endproperty
    a_power_lock: assert property (p_power_lock) else $error("write taken in power lock");

    property p_otp_lock;
        nv.lock_mode == LOCK_OTP && !FACTORY_RST |=> nv.lock_mode == LOCK_OTP;
    endproperty
    a_otp_lock: assert property (p_otp_lock) else $error("permanent lock mode left");

    property p_sec_keep;
        !FACTORY_RST |=> (($past(sec_now) & ~sec_now) == 3'h0);
    endproperty
    a_sec_keep: assert property (p_sec_keep) else $error("security lock cleared");

    property p_prot_refuse;
        state == ST_CHECK && PROT_HIT |=> !PE_START;
    endproperty
    a_prot_refuse: assert property (p_prot_refuse) else $error("protected target started");

    property p_chip_guard;
        pe_go && is_all && !chip_ok |=> !PE_START ##1 !PE_START;
    endproperty
    a_chip_guard: assert property (p_chip_guard) else $error("full erase while protected");

    property p_forbid;
        ev && op == OP_WRITE_FORBID && frame.bits == BITS_CMD |=> !write_permit_latch;
    endproperty
    a_forbid: assert property (p_forbid) else $error("latch kept after forbid");

    property p_partial;
        ev && is_wr_op && frame.bits != BITS_WRITE |-> !nv_wr;
    endproperty
    a_partial: assert property (p_partial) else $error("partial status write taken");

    property p_suspend;
        suspend_ev |=> (PE_KIND == KIND_PROGRAM ? program_paused : erase_paused)
            ##1 (PE_KIND == KIND_PROGRAM ? STATUS[10] : STATUS[15]);
    endproperty
    a_suspend: assert property (p_suspend) else $error("pause flag missing");

    property p_resume;
        resume_ev |=> !erase_paused && !program_paused;
    endproperty
    a_resume: assert property (p_resume) else $error("pause flags kept after resume");

    c_status_write: cover property (nv_wr ##[1:20] state == ST_IDLE);
    c_erase_start: cover property (PE_START && PE_KIND == KIND_ERASE_AREA);
    c_suspend_resume: cover property (suspend_ev ##[1:200] resume_ev);
endmodule : fsr_status_bank

// file: inc/fsr_pkg.sv
// status bank package: command codes, frame lengths, field layout, reset values, timing
// assumes a 250 MHz system clock and a serial link clock from the host
package fsr_pkg;
    // command codes
    localparam logic [7:0] OP_WRITE_PERMIT = 8'h06;
    localparam logic [7:0] OP_WRITE_FORBID = 8'h04;
    localparam logic [7:0] OP_READ_LOW = 8'h05;
    localparam logic [7:0] OP_READ_MID = 8'h35;
    localparam logic [7:0] OP_READ_HIGH = 8'h15;
    localparam logic [7:0] OP_WRITE_LOW = 8'h01;
    localparam logic [7:0] OP_WRITE_MID = 8'h31;
    localparam logic [7:0] OP_WRITE_HIGH = 8'h11;
    localparam logic [7:0] OP_PROGRAM = 8'h02;
    localparam logic [7:0] OP_PROGRAM_QUAD = 8'h32;
    localparam logic [7:0] OP_PROGRAM_FAST = 8'hF2;
    localparam logic [7:0] OP_WIPE_SMALL = 8'h20;
    localparam logic [7:0] OP_WIPE_BLOCK32 = 8'h52;
    localparam logic [7:0] OP_WIPE_BLOCK64 = 8'hD8;
    localparam logic [7:0] OP_WIPE_ALL_A = 8'h60;
    localparam logic [7:0] OP_WIPE_ALL_B = 8'hC7;
    localparam logic [7:0] OP_RESET_ARM = 8'h66;
    localparam logic [7:0] OP_RESET_GO = 8'h99;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7A;
    // frame lengths in serial clocks
    localparam logic [11:0] BITS_CMD = 12'h008;
    localparam logic [11:0] BITS_WRITE = 12'h010;
    localparam logic [11:0] BITS_ADDR = 12'h020;
    localparam logic [11:0] BITS_PROGRAM_MIN = 12'h028;
    localparam logic [11:0] BITS_MAX = 12'hFFF;
    // field positions inside a written data byte
    localparam int POS_LOCK_LO = 7;
    localparam int POS_AREA = 2;
    localparam int POS_LOCK_HI = 0;
    localparam int POS_FOUR_LANE = 1;
    localparam int POS_SEC = 3;
    localparam int POS_INVERT = 6;
    localparam int POS_DRIVE = 5;
    // lock modes
    localparam logic [1:0] LOCK_SOFT = 2'h0;
    localparam logic [1:0] LOCK_PIN = 2'h1;
    localparam logic [1:0] LOCK_POWER = 2'h2;
    localparam logic [1:0] LOCK_OTP = 2'h3;
    // timing
    localparam int STATUS_WRITE_NS = 1000;
    localparam int SYS_CLK_MHZ = 250;
    localparam int STATUS_WRITE_CYC = (STATUS_WRITE_NS * SYS_CLK_MHZ + 999) / 1000;

    typedef struct packed {
        logic [1:0] drive;
        logic invert;
        logic [2:0] sec_lock;
        logic four_lane;
        logic [1:0] lock_mode;
        logic [4:0] area;
    } fsr_nv_t;

    localparam fsr_nv_t NV_DEFAULT = '{drive: 2'h1, invert: 1'h0, sec_lock: 3'h0,
        four_lane: 1'h0, lock_mode: LOCK_SOFT, area: 5'h00};

    typedef struct packed {
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [11:0] bits;
    } fsr_frame_t;

    typedef enum logic [1:0] {
        KIND_PROGRAM = 2'b00,
        KIND_ERASE_AREA = 2'b01,
        KIND_ERASE_ALL = 2'b10
    } fsr_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CHECK = 2'b01,
        ST_SWRITE = 2'b10
    } fsr_state_t;
endpackage : fsr_pkg

// file: rtl/fsr_link.sv
// serial link end: shifts in command frames on the host clock, shifts status out
// assumes rst is held for several link clocks; status_word is frozen while cs_n is low
`timescale 1ns/1ps
module fsr_link
    import fsr_pkg::*;
(
    input wire logic sck,
    input wire logic cs_n,
    input wire logic rst,
    input wire logic si,
    input wire logic [23:0] status_word,
    output fsr_frame_t frame,
    output logic seq,
    output logic so,
    output logic so_oe
);
    logic [11:0] count;
    logic [6:0] sh;
    logic [7:0] rd_byte;
    logic rd_op;

    // the select clears the bit count, no link edge is needed at frame end
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            count <= 12'h000;
            sh <= 7'h00;
        end else begin
            if (count != BITS_MAX) begin
                count <= count + 12'h001;
            end
            sh <= {sh[5:0], si};
        end
    end

    // record outlives the select so the system side can take it over
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            frame <= '0;
            seq <= 1'b0;
        end else if (!cs_n) begin
            frame.bits <= (count != BITS_MAX) ? count + 12'h001 : count;
            if (count == 12'h000) begin
                seq <= !seq;
            end
            if (count == 12'h007) begin
                frame.opcode <= {sh, si};
            end else if (count >= 12'h008 && count < BITS_ADDR) begin
                frame.addr <= {frame.addr[22:0], si};
            end
        end
    end

    always_comb begin
        rd_op = 1'b1;
        case (frame.opcode)
            OP_READ_LOW: rd_byte = status_word[7:0];
            OP_READ_MID: rd_byte = status_word[15:8];
            OP_READ_HIGH: rd_byte = status_word[23:16];
            default: begin
                rd_byte = 8'h00;
                rd_op = 1'b0;
            end
        endcase
    end

    // byte repeats until the bit count saturates at BITS_MAX, then bit 0 of the byte is held
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            so <= 1'b0;
            so_oe <= 1'b0;
        end else begin
            so_oe <= rd_op && count >= BITS_CMD;
            so <= rd_byte[~count[2:0]];
        end
    end
endmodule : fsr_link

// file: rtl/fsr_nv_store.sv
// non-volatile image of the status bits
// assumes factory_rst is given once before use; power_rst models a power cycle
`timescale 1ns/1ps
module fsr_nv_store
    import fsr_pkg::*;
(
    input wire logic clk,
    input wire logic factory_rst,
    input wire logic power_rst,
    input wire logic wr_en,
    input wire fsr_nv_t wr_data,
    output fsr_nv_t nv
);
    always_ff @(posedge clk) begin
        if (factory_rst) begin
            nv <= NV_DEFAULT;
        end else if (power_rst) begin
            if (nv.lock_mode == LOCK_POWER) begin
                nv.lock_mode <= LOCK_SOFT;
            end
        end else if (wr_en) begin
            nv <= wr_data;
            nv.sec_lock <= nv.sec_lock | wr_data.sec_lock;
        end
    end
endmodule : fsr_nv_store

// file: sim/fsr_host_model.sv
// host controller model: sends frames msb first, reads status bytes back
// assumes frames are spaced by the bench; sck stands low between frames
`timescale 1ns/1ps
module fsr_host_model (
    output logic SCK,
    output logic CS_N,
    output logic SI,
    input wire logic SO
);
    initial begin
        SCK = 1'b0;
        CS_N = 1'b1;
        SI = 1'b0;
    end
    // n bits of w out, then r_n bits read on rising edges
    task automatic xfer(input logic [39:0] w, input int n, input int r_n,
        output logic [7:0] rd);
        rd = 8'h00;
        CS_N = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            SI = w[i];
            #7.5 SCK = 1'b1;
            #7.5 SCK = 1'b0;
        end
        for (int i = 0; i < r_n; i++) begin
            SI = ~SI; // unused line, never a held value
            #7.5 SCK = 1'b1;
            rd = {rd[6:0], SO};
            #7.5 SCK = 1'b0;
        end
        #7.5 CS_N = 1'b1; // raised after whole bytes unless bench cuts a frame
        SI = ~SI;
        #40;
    endtask : xfer
endmodule : fsr_host_model

// file: sim/fsr_status_bank_tb_top.sv
// bench for the status bank: table of status writes and reads, then hand cases
// assumes the host model on the link and a small engine model on SYS_CLK
`timescale 1ns/1ps
module fsr_status_bank_tb_top;
    import fsr_pkg::*;
    typedef struct packed {
        logic [7:0] op;
        logic [7:0] wd;
        logic [7:0] rop;
        logic [7:0] exp;
    } fsr_row_t;
    logic SYS_CLK, RST, FACTORY_RST, SCK, CS_N, SI, SO, SO_OE, WP_N, HIGH_SPEED_MODE;
    logic PE_BUSY, PROT_HIT, PE_START, PE_SUSPEND, PE_RESUME, SOFT_RESET, QUAD_LANES_ON;
    logic PROTECT_INVERT;
    fsr_kind_t PE_KIND;
    logic [23:0] PE_ADDR, STATUS;
    logic [4:0] AREA_PROTECT;
    logic [2:0] SEC_REG_READ_ONLY;
    logic [1:0] DRIVE_STRENGTH;
    logic [7:0] rd;
    int bad_count = 0;
    int n_compared = 0;
    int n_start = 0;
    int busy_left = 0;
    int cyc = 0;
    int n_sus = 0, n_res = 0, n_soft = 0, n_oe = 0;
    // four-lane bit never set: protect and pause pins are tied here
    fsr_row_t rows [9] = '{
        '{8'h01, 8'h7C, 8'h05, 8'h7C},
        '{8'h01, 8'h00, 8'h05, 8'h00},
        '{8'h31, 8'h84, 8'h35, 8'h00},
        '{8'h31, 8'h48, 8'h35, 8'h48},
        '{8'h31, 8'h00, 8'h35, 8'h08},
        '{8'h11, 8'hFF, 8'h15, 8'h60},
        '{8'h11, 8'h00, 8'h15, 8'h00},
        '{8'h11, 8'h40, 8'h15, 8'h40},
        '{8'h11, 8'h20, 8'h15, 8'h20}};

    fsr_status_bank #(.WRITE_CYC(8)) u_dut (.SYS_CLK, .RST, .FACTORY_RST, .SCK, .CS_N,
        .SI, .SO, .SO_OE, .WP_N, .HIGH_SPEED_MODE, .PE_BUSY, .PROT_HIT, .PE_START,
        .PE_KIND, .PE_ADDR, .PE_SUSPEND, .PE_RESUME, .SOFT_RESET, .QUAD_LANES_ON,
        .AREA_PROTECT, .PROTECT_INVERT, .SEC_REG_READ_ONLY, .DRIVE_STRENGTH, .STATUS);
    fsr_host_model u_host (.SCK, .CS_N, .SI, .SO);

    initial begin
        SYS_CLK = 1'b0;
        forever #2 SYS_CLK = ~SYS_CLK;
    end
    // crude map: any low area bit protects every address
    assign PROT_HIT = |AREA_PROTECT[2:0];
    always @(negedge SYS_CLK) begin
        if (PE_START === 1'b1) begin
            busy_left = 400;
            n_start++;
        end else if (busy_left > 0)
            busy_left--;
        PE_BUSY = busy_left > 0;
        n_sus += (PE_SUSPEND === 1'b1);
        n_res += (PE_RESUME === 1'b1);
        n_soft += (SOFT_RESET === 1'b1);
        n_oe += (SO_OE === 1'b1);
        cyc++;
        if (cyc > 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic fr(input logic [39:0] w, input int n);
        logic [7:0] d;
        u_host.xfer(w, n, 0, d);
        repeat (8) @(negedge SYS_CLK);
        for (int i = 0; i < 2000 && STATUS[0] !== 1'b0; i++)
            @(negedge SYS_CLK);
    endtask : fr
    task automatic wr(input logic [7:0] op, input logic [7:0] d);
        fr(8'h06, 8);
        fr({op, d}, 16);
    endtask : wr
    task automatic rdb(input logic [7:0] op, input logic [7:0] exp, input string nm);
        u_host.xfer({32'h0, op}, 8, 8, rd);
        chk(nm, {16'h0, rd}, {16'h0, exp});
    endtask : rdb
    task automatic pin(input logic v);
        @(negedge SYS_CLK);
        WP_N = v;
    endtask : pin
    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    initial begin
        RST = 1'b1;
        FACTORY_RST = 1'b1;
        WP_N = 1'b1;
        HIGH_SPEED_MODE = 1'b0;
        @(negedge SYS_CLK);
        FACTORY_RST = 1'b0;
        repeat (4) @(negedge SYS_CLK);
        RST = 1'b0;
        @(negedge SYS_CLK);
        foreach (rows[i]) begin
            wr(rows[i].op, rows[i].wd);
            rdb(rows[i].rop, rows[i].exp, "row");
        end
        @(negedge SYS_CLK);
        HIGH_SPEED_MODE = 1'b1;
        rdb(8'h15, 8'h30, "high speed");
        @(negedge SYS_CLK);
        HIGH_SPEED_MODE = 1'b0;
        $display("table done");
        fr(8'h06, 8);
        rdb(8'h05, 8'h02, "latch set");
        fr({8'h01, 8'h1C} >> 1, 15);
        rdb(8'h05, 8'h02, "cut frame");
        fr(8'h04, 8);
        rdb(8'h05, 8'h00, "latch clear");
        fr({8'h01, 8'h1C}, 16);
        rdb(8'h05, 8'h00, "no latch");
        $display("latch done");
        wr(8'h01, 8'h80);
        pin(1'b0);
        wr(8'h01, 8'h9C);
        rdb(8'h05, 8'h80, "pin lock");
        pin(1'b1);
        wr(8'h01, 8'h9C);
        rdb(8'h05, 8'h9C, "pin free");
        wr(8'h01, 8'h00);
        wr(8'h31, 8'h01);
        wr(8'h01, 8'h1C);
        rdb(8'h05, 8'h00, "power lock");
        @(negedge SYS_CLK);
        RST = 1'b1;
        repeat (4) @(negedge SYS_CLK);
        RST = 1'b0;
        repeat (2) @(negedge SYS_CLK);
        chk("after power", STATUS, 24'h200800);
        chk("levels", {QUAD_LANES_ON, PROTECT_INVERT, SEC_REG_READ_ONLY, DRIVE_STRENGTH,
            AREA_PROTECT}, 24'h0000A0);
        pin(1'b0);
        wr(8'h01, 8'h04);
        rdb(8'h05, 8'h04, "soft lock");
        pin(1'b1);
        $display("lock done");
        fr(8'h06, 8);
        fr({8'h20, 24'h7FF000}, 32);
        fr(8'h06, 8);
        fr(8'h60, 8);
        chk("protected", n_start, 0);
        wr(8'h01, 8'h00);
        fr(8'h06, 8);
        u_host.xfer({8'h20, 24'h012345}, 32, 0, rd);
        repeat (12) @(negedge SYS_CLK);
        chk("start", n_start, 1);
        chk("addr", PE_ADDR, 24'h012345);
        chk("kind", PE_KIND, KIND_ERASE_AREA);
        rdb(8'h05, 8'h01, "busy");
        u_host.xfer(40'h75, 8, 0, rd);
        rdb(8'h35, 8'h88, "paused");
        fr(8'h7A, 8);
        rdb(8'h35, 8'h08, "resumed");
        fr(8'h06, 8);
        fr(8'h60, 8);
        chk("full erase", PE_KIND, KIND_ERASE_ALL);
        $display("erase done");
        fr(8'h06, 8);
        fr(8'h66, 8);
        fr(8'h99, 8);
        rdb(8'h05, 8'h00, "soft reset");
        wr(8'h01, 8'h80);
        wr(8'h31, 8'h09);
        wr(8'h01, 8'h1C);
        rdb(8'h05, 8'h80, "otp lock");
        chk("pulses", {6'(n_start), 6'(n_sus), 6'(n_res), 6'(n_soft)}, 24'h081041);
        chk("oe", {SO_OE, n_oe != 0}, 24'h000001);
        $display("reset done");
        tally_and_finish();
    end
endmodule : fsr_status_bank_tb_top
